// ### hw/spc_pkg.sv
// Constants and carrier types for the serial port configuration register bank.
`default_nettype none
package spc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [11:0] SERIAL_PORT_SETUP_ADDR = 12'h000;
  localparam logic [11:0] READBACK_SOURCE_SELECT_ADDR = 12'h004;
  localparam logic [11:0] USER_VERSION_TAG_LOW_ADDR = 12'h005;
  localparam logic [11:0] USER_VERSION_TAG_HIGH_ADDR = 12'h006;

  // Field positions in serial_port_setup.
  localparam int unsigned OUTPUT_PIN_SELECT_BIT = 7;
  localparam int unsigned LSB_FIRST_BIT = 6;
  localparam int unsigned SOFT_RESET_BIT = 5;
  localparam int unsigned SETUP_RSVD_BIT = 4;

  // Field position in readback_source_select.
  localparam int unsigned READBACK_SHADOW_BIT = 0;

  // Reset values.
  localparam logic OUTPUT_PIN_SELECT_RST = 1'b0;
  localparam logic LSB_FIRST_RST = 1'b0;
  localparam logic READBACK_SHADOW_RST = 1'b0;
  localparam logic [7:0] USER_VERSION_TAG_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Number of buffered byte registers (the two version tag bytes).
  localparam int unsigned NUM_BUFFERED = 2;

  // One register access from the serial protocol engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } spc_reg_req_s;

  // Bit-serial readback request from the serial protocol engine.
  typedef struct packed {
    logic drive;
    logic bit_value;
  } spc_read_bit_s;

endpackage

`default_nettype wire

// ### hw/spc_buffered_byte.sv
// One buffered byte register: a shadow copy written by software and an active copy.
`timescale 1ns/1ps
`default_nettype none

module spc_buffered_byte
  import spc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic soft_rst_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic update_apply_i,
  output logic [7:0] shadow_o,
  output logic [7:0] active_o
);

  // A write in the same cycle as the apply command lands in the shadow only;
  // the active copy takes the shadow value that stood before that write.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shadow_o <= USER_VERSION_TAG_RST;
    end else if (soft_rst_i) begin
      shadow_o <= USER_VERSION_TAG_RST;
    end else if (wr_i) begin
      shadow_o <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_o <= USER_VERSION_TAG_RST;
    end else if (soft_rst_i) begin
      active_o <= USER_VERSION_TAG_RST;
    end else if (update_apply_i) begin
      active_o <= shadow_o;
    end
  end

endmodule

`default_nettype wire

// ### hw/spc_config_regs.sv
// Serial port configuration register bank with pin steering and soft reset.
//
// How it works
// - Select bit 0: reads and writes on the data pin; output pin undriven.
// - Select bit 1: writes on data pin, reads driven only on output pin.
// - In I2C mode both mode bits are ignored and read as reserved.
// - Order bit 0: MSB first, address decrements in multi-byte transfers.
// - Order bit 1: LSB first, address increments in multi-byte transfers.
// - Writing soft reset bit restores all defaults; bit clears itself.
// - Readback select 0: buffered registers read their active values.
// - Readback select 1: buffered registers read pending shadow values.
// - Sixteen-bit version tag at two addresses, stored only, no effect.
`timescale 1ns/1ps
`default_nettype none

module spc_config_regs
  import spc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Port protocol in use: 1 when the I2C framing is active.
  input wire logic i2c_mode_i,
  // Register access from the serial protocol engine.
  input wire spc_reg_req_s req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Update-apply command, one-cycle pulse.
  input wire logic update_apply_i,
  // Bit-serial readback from the protocol engine.
  input wire spc_read_bit_s read_bit_i,
  // Bidirectional data pin, output half.
  output logic data_pin_o,
  output logic data_pin_oe_o,
  // Separate serial output pin.
  output logic serial_output_pin_o,
  output logic serial_output_pin_oe_o,
  // Effective transfer settings for the protocol engine.
  output logic lsb_first_o,
  output logic addr_increment_o,
  // Soft reset pulse to the rest of the device.
  output logic soft_reset_o,
  // Active user version tag.
  output logic [15:0] user_version_tag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
    addr_hit = (a == target);
  endfunction

  logic wr_setup;
  logic wr_readback;
  logic [NUM_BUFFERED-1:0] wr_buffered;

  assign wr_setup = req_i.wr && addr_hit(req_i.addr, SERIAL_PORT_SETUP_ADDR);
  assign wr_readback = req_i.wr && addr_hit(req_i.addr, READBACK_SOURCE_SELECT_ADDR);
  assign wr_buffered[0] = req_i.wr && addr_hit(req_i.addr, USER_VERSION_TAG_LOW_ADDR);
  assign wr_buffered[1] = req_i.wr && addr_hit(req_i.addr, USER_VERSION_TAG_HIGH_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset

  // The pulse is held one cycle only, so the stored bit is always back to
  // zero by the time any read can see it. A write that arrives while the pulse
  // stands is lost, like every other write in that cycle, so the pulse never stretches.
  logic soft_rst;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_setup && req_i.wdata[SOFT_RESET_BIT] && !soft_rst;
    end
  end

  assign soft_reset_o = soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Unbuffered setup registers

  logic output_pin_select;
  logic lsb_first;
  logic readback_shadow;

  // Bits 7 and 6 are stored only outside I2C mode, so a host in I2C mode
  // cannot disturb a later SPI session by writing reserved bits.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_pin_select <= OUTPUT_PIN_SELECT_RST;
      lsb_first <= LSB_FIRST_RST;
    end else if (soft_rst) begin
      output_pin_select <= OUTPUT_PIN_SELECT_RST;
      lsb_first <= LSB_FIRST_RST;
    end else if (wr_setup && !i2c_mode_i) begin
      output_pin_select <= req_i.wdata[OUTPUT_PIN_SELECT_BIT];
      lsb_first <= req_i.wdata[LSB_FIRST_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      readback_shadow <= READBACK_SHADOW_RST;
    end else if (soft_rst) begin
      readback_shadow <= READBACK_SHADOW_RST;
    end else if (wr_readback) begin
      readback_shadow <= req_i.wdata[READBACK_SHADOW_BIT];
    end
  end

  logic eff_output_pin_select;
  logic eff_lsb_first;

  assign eff_output_pin_select = output_pin_select && !i2c_mode_i;
  assign eff_lsb_first = lsb_first && !i2c_mode_i;

  assign lsb_first_o = eff_lsb_first;
  assign addr_increment_o = eff_lsb_first;

  ////////////////////////////////////////////////////////////////////////////
  // Buffered version tag

  logic [7:0] tag_shadow [NUM_BUFFERED];
  logic [7:0] tag_active [NUM_BUFFERED];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUFFERED; gi++) begin : g_tag
      spc_buffered_byte u_byte (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .soft_rst_i(soft_rst),
        .wr_i(wr_buffered[gi]),
        .wdata_i(req_i.wdata),
        .update_apply_i(update_apply_i),
        .shadow_o(tag_shadow[gi]),
        .active_o(tag_active[gi])
      );
    end
  endgenerate

  // The tag leaves the bank only as an observable value; nothing here uses it.
  assign user_version_tag_o = {tag_active[1], tag_active[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Readback

  function automatic logic [7:0] setup_readback(input logic ops, input logic lsb,
                                                input logic i2c);
    logic [3:0] upper;
    upper = {(ops && !i2c), (lsb && !i2c), 1'b0, 1'b0};
    setup_readback = {upper, upper[0], upper[1], upper[2], upper[3]};
  endfunction

  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = UNMAPPED_READ_VALUE;
    case (req_i.addr)
      SERIAL_PORT_SETUP_ADDR: begin
        next_rd_data = setup_readback(output_pin_select, lsb_first, i2c_mode_i);
      end
      READBACK_SOURCE_SELECT_ADDR: begin
        next_rd_data = {7'h00, readback_shadow};
      end
      USER_VERSION_TAG_LOW_ADDR: begin
        next_rd_data = readback_shadow ? tag_shadow[0] : tag_active[0];
      end
      USER_VERSION_TAG_HIGH_ADDR: begin
        next_rd_data = readback_shadow ? tag_shadow[1] : tag_active[1];
      end
      default: begin
        next_rd_data = UNMAPPED_READ_VALUE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= UNMAPPED_READ_VALUE;
    end else if (req_i.rd) begin
      rd_data_o <= next_rd_data;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin steering

  // Registered so the pins never glitch on a decode of the request lines.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_pin_o <= 1'b0;
      data_pin_oe_o <= 1'b0;
      serial_output_pin_o <= 1'b0;
      serial_output_pin_oe_o <= 1'b0;
    end else if (eff_output_pin_select) begin
      data_pin_o <= 1'b0;
      data_pin_oe_o <= 1'b0;
      serial_output_pin_o <= read_bit_i.bit_value;
      serial_output_pin_oe_o <= read_bit_i.drive;
    end else begin
      data_pin_o <= read_bit_i.bit_value;
      data_pin_oe_o <= read_bit_i.drive;
      serial_output_pin_o <= 1'b0;
      serial_output_pin_oe_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### dv/spc_config_regs_props.sv
// Port assertions for the serial port configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module spc_config_regs_props
  import spc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic i2c_mode_i,
  input wire spc_reg_req_s req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic update_apply_i,
  input wire spc_read_bit_s read_bit_i,
  input wire logic data_pin_o,
  input wire logic data_pin_oe_o,
  input wire logic serial_output_pin_o,
  input wire logic serial_output_pin_oe_o,
  input wire logic lsb_first_o,
  input wire logic addr_increment_o,
  input wire logic soft_reset_o,
  input wire logic [15:0] user_version_tag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////
  chk_read_answered: assert property (req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  chk_no_stray_valid: assert property (!req_i.rd |=> !rd_valid_o)
    else $error("valid without read");
  chk_soft_rst_pulse: assert property (req_i.wr && !soft_reset_o
    && req_i.addr == SERIAL_PORT_SETUP_ADDR && req_i.wdata[5] |=> soft_reset_o)
    else $error("soft reset not raised");
  chk_soft_rst_clears: assert property (soft_reset_o |=> !soft_reset_o
    && user_version_tag_o == 16'h0000 && !lsb_first_o) else $error("soft reset incomplete");
  chk_i2c_order_off: assert property (i2c_mode_i |-> !lsb_first_o)
    else $error("bit order used in i2c");
  chk_step_matches: assert property (addr_increment_o == lsb_first_o)
    else $error("address step differs from bit order");
  chk_one_pin_only: assert property (read_bit_i.drive |=> data_pin_oe_o ^ serial_output_pin_oe_o)
    else $error("read not on exactly one pin");
  chk_pins_idle: assert property (!read_bit_i.drive |=> !data_pin_oe_o && !serial_output_pin_oe_o)
    else $error("pin driven while idle");
  chk_tag_holds: assert property (!update_apply_i && !soft_reset_o |=> $stable(user_version_tag_o))
    else $error("active tag moved without apply");
endmodule
bind spc_config_regs spc_config_regs_props chk_u (.*);
`default_nettype wire

// ### dv/spc_host_model.sv
// Host-side model that shifts one read byte onto the bit-serial readback port.
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
  import spc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [7:0] byte_i,
  input wire logic lsb_first_i,
  output var spc_read_bit_s read_bit_o
);
  logic [3:0] cnt;
  logic [7:0] sr;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 4'h0;
      sr <= 8'h00;
      read_bit_o <= '0;
    end else if (go_i) begin
      cnt <= 4'h7;
      sr <= lsb_first_i ? byte_i >> 1 : byte_i << 1;
      read_bit_o <= {1'b1, lsb_first_i ? byte_i[0] : byte_i[7]};
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      sr <= lsb_first_i ? sr >> 1 : sr << 1;
      read_bit_o <= {1'b1, lsb_first_i ? sr[0] : sr[7]};
    end else begin
      // Idle bit toggles so a stale value never passes for a driven one.
      read_bit_o <= {1'b0, ~read_bit_o.bit_value};
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_spc_config_regs.sv
// Self-checking testbench for the serial port configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_spc_config_regs;
  import spc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic i2c = 1'b0;
  logic apply = 1'b0;
  logic go = 1'b0;
  logic [7:0] go_byte = 8'h00;
  spc_reg_req_s req = '0;
  spc_read_bit_s rbit;
  logic [7:0] rdata;
  logic rvalid, dpin, dpin_oe, so, so_oe, lsb, inc, srst;
  logic [15:0] tag;
  int n_errors = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  spc_config_regs dut_u (.core_clk_i(clk), .nrst_i(nrst), .i2c_mode_i(i2c), .req_i(req),
    .rd_data_o(rdata), .rd_valid_o(rvalid), .update_apply_i(apply), .read_bit_i(rbit),
    .data_pin_o(dpin), .data_pin_oe_o(dpin_oe), .serial_output_pin_o(so),
    .serial_output_pin_oe_o(so_oe), .lsb_first_o(lsb), .addr_increment_o(inc),
    .soft_reset_o(srst), .user_version_tag_o(tag));
  spc_host_model host_u (.core_clk_i(clk), .nrst_i(nrst), .go_i(go), .byte_i(go_byte),
    .lsb_first_i(lsb), .read_bit_o(rbit));
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask
  // The read bit shows on a pin one cycle after the model presents it.
  task automatic shift(input logic [7:0] b, input logic lsb_exp, input logic ops);
    @(posedge clk);
    go <= 1'b1;
    go_byte <= b;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      chk(ops ? so : dpin, lsb_exp ? b[i] : b[7 - i]);
      chk(ops ? {so_oe, dpin_oe} : {dpin_oe, so_oe}, 2'b10);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(SERIAL_PORT_SETUP_ADDR, 8'h00);
    rd(READBACK_SOURCE_SELECT_ADDR, 8'h00);
    rd(USER_VERSION_TAG_HIGH_ADDR, 8'h00);
    rd(12'h123, 8'h00);
    $display("test reset_values done");
    wr(USER_VERSION_TAG_LOW_ADDR, 8'hab);
    wr(USER_VERSION_TAG_HIGH_ADDR, 8'hcd);
    rd(USER_VERSION_TAG_LOW_ADDR, 8'h00);
    wr(READBACK_SOURCE_SELECT_ADDR, 8'h01);
    rd(READBACK_SOURCE_SELECT_ADDR, 8'h01);
    rd(USER_VERSION_TAG_HIGH_ADDR, 8'hcd);
    @(posedge clk);
    apply <= 1'b1;
    @(posedge clk);
    apply <= 1'b0;
    #1;
    chk(tag, 16'hcdab);
    wr(READBACK_SOURCE_SELECT_ADDR, 8'h00);
    rd(USER_VERSION_TAG_LOW_ADDR, 8'hab);
    $display("test buffered_tag done");
    wr(SERIAL_PORT_SETUP_ADDR, 8'hc3);
    rd(SERIAL_PORT_SETUP_ADDR, 8'hc3);
    chk({lsb, inc}, 2'b11);
    shift(8'h96, 1'b1, 1'b1);
    @(posedge clk);
    i2c <= 1'b1;
    wr(SERIAL_PORT_SETUP_ADDR, 8'h00);
    rd(SERIAL_PORT_SETUP_ADDR, 8'h00);
    chk({lsb, inc}, 2'b00);
    shift(8'h96, 1'b0, 1'b0);
    @(posedge clk);
    i2c <= 1'b0;
    rd(SERIAL_PORT_SETUP_ADDR, 8'hc3);
    $display("test pin_modes done");
    wr(SERIAL_PORT_SETUP_ADDR, 8'he7);
    #1;
    chk(srst, 1'b1);
    rd(SERIAL_PORT_SETUP_ADDR, 8'h00);
    rd(USER_VERSION_TAG_LOW_ADDR, 8'h00);
    chk(tag, 16'h0000);
    shift(8'h96, 1'b0, 1'b0);
    $display("test soft_reset done");
    summarize();
  end
endmodule
`default_nettype wire
